// File: hdl/tob_regs.vh
`ifndef TOB_REGS_VH
`define TOB_REGS_VH
// Register byte addresses (index times four)
`define TOB_IDX_DCP 8'hf0
`define TOB_IDX_OBC 8'hfd
`define TOB_IDX_FLG 8'hfe
`define TOB_IDX_MSK 8'hff
`define TOB_ADDR_DCP 12'h3c0
`define TOB_ADDR_OBC 12'h3f4
`define TOB_ADDR_FLG 12'h3f8
`define TOB_ADDR_MSK 12'h3fc
// Reset values
`define TOB_RST_BYTE 8'h00
// Output action codes
`define TOB_ACT_SET 2'h0
`define TOB_ACT_TGL 2'h1
`define TOB_ACT_CLR 2'h2
`define TOB_ACT_NOP 2'h3
// Control field positions
`define TOB_OBC_C0_HI 7
`define TOB_OBC_C0_LO 6
`define TOB_OBC_C1_HI 5
`define TOB_OBC_C1_LO 4
`define TOB_OBC_OU_HI 3
`define TOB_OBC_OU_LO 2
`define TOB_OBC_OEV 1
`define TOB_OBC_OP 0
// Flag bits
`define TOB_FLG_CP0 7
`define TOB_FLG_CP1 6
`define TOB_FLG_CM0 5
`define TOB_FLG_CM1 4
`define TOB_FLG_OUF 3
`define TOB_FLG_CAPTURE_ZERO_OVERRUN 2
`define TOB_FLG_COMPARE_ZERO_OVERRUN 1
`define TOB_FLG_A0 0
// Mask bits
`define TOB_MSK_GLOBAL_TIMER_IRQ_ENABLE 7
`define TOB_MSK_CAPTURE_ZERO_DMA_MASK 6
`define TOB_MSK_CAPTURE_ZERO_IRQ_MASK 5
`define TOB_MSK_CAPTURE_ONE_IRQ_MASK 4
`define TOB_MSK_COMPARE_ZERO_DMA_MASK 3
`define TOB_MSK_COMPARE_ZERO_IRQ_MASK 2
`define TOB_MSK_COMPARE_ONE_IRQ_MASK 1
`define TOB_MSK_OUI 0
// Pointer bits
`define TOB_DCP_PTR2 2
`define TOB_DCP_DIR 1
`define TOB_DCP_AREA 0
// AXI responses
`define TOB_RESP_OKAY 2'h0
`define TOB_RESP_SLVERR 2'h2
`endif

// File: hdl/tob_timer_out_b.v
// What this block does
// - Compare-0 match drives pin B per action bits 7:6: set, toggle, reset, nop.
// - Compare-1 match drives pin B per action bits 5:4, same encoding.
// - Counter wrap drives pin B per action bits 3:2, same encoding.
// - Coinciding events: effective code is bitwise AND of their codes.
// - Wrap with event enable set gives a one-cycle on-chip event pulse.
// - Preset bit sets pin B level; reading it returns the pin level.
// - Capture-0 sets its flag; software setting it acts as capture 0.
// - Capture-1 sets its flag; software set captures 1 except bicapture.
// - Compare matches set compare flags; interrupt when global and own mask set.
// - Wrap sets wrap flag; interrupt when global enable and wrap mask set.
// - Capture-0 overrun on repeated request before clear or software capture.
// - Compare-0 overrun on repeated request before compare-0 flag cleared.
// - Combine bit 0 ORs capture interrupts, 1 ANDs them; software sets both masks.
// - Global enable 0 blocks all interrupts; 1 passes enabled sources.
// - Capture-0 DMA mask set by software, cleared by hardware at block end.
// - With capture-0 DMA mask set, capture-0 irq mask enables end-of-block irq.
// - Compare-0 DMA mask likewise; its irq mask then enables end-of-block irq.
// - Capture-1, compare-1 and wrap interrupts gated by their own masks.
// - Pointer bits 7:2 give DMA counter address MSBs; swap may toggle bit 2.
// - Direction bit driven by hardware: 0 capture-0 source, 1 compare-0 target.
// - Area bit selects memory (0) or register file (1) for DMA.
// - Swap enable permits pointer bit 2 toggling, at compare-0 DMA end of block only.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tob_regs.vh"
module tob_timer_out_b (
  input wire ref_clk, // Timer clock, 100 MHz
  input wire rst_n, // Async reset, active low
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read valid
  input wire s_axi_rready, // Read ready
  input wire cmp0_match, // Compare-0 match pulse
  input wire cmp1_match, // Compare-1 match pulse
  input wire cnt_wrap, // Counter overflow/underflow pulse
  input wire cap0_event, // Hardware capture into register 0
  input wire cap1_event, // Hardware capture into register 1
  input wire bicapture_mode, // Timer in bicapture mode
  input wire swap_enable, // Swap mode; pointer bit 2 toggles at compare-0 DMA end of block
  input wire cap0_dma_req, // Capture-0 DMA request served
  input wire cmp0_dma_req, // Compare-0 DMA request served
  input wire cap0_dma_eob, // Capture-0 DMA end of block
  input wire cmp0_dma_eob, // Compare-0 DMA end of block
  input wire dma_dir_cmp, // Active channel is compare-0
  output reg timer_output_pin_b, // Output pin B level
  output reg wrap_event_pulse, // On-chip event pulse
  output reg sw_capture0_pulse, // Software capture on register 0
  output reg sw_capture1_pulse, // Software capture on register 1
  output reg capture_irq, // Capture group interrupt
  output reg compare_irq, // Compare group interrupt
  output reg wrap_irq, // Wrap interrupt
  output reg [7:0] dma_counter_pointer_q, // Pointer register view
  output reg [7:0] interrupt_dma_mask_q // Mask register view
);

  reg [7:1] obc_r; // Action bits and event enable
  reg [7:0] flg_r;
  reg [7:0] msk_r;
  reg [7:2] ptr_r;
  reg dir_r;
  reg area_r;
  reg [11:0] awaddr_r;
  reg aw_have_r;
  reg [7:0] wdata_r;
  reg w_have_r;
  reg w_strb_r;

  // Register select codes from the address decoder
  localparam [2:0] sel_none = 3'h0;
  localparam [2:0] sel_dcp = 3'h1;
  localparam [2:0] sel_obc = 3'h2;
  localparam [2:0] sel_flg = 3'h3;
  localparam [2:0] sel_msk = 3'h4;

  // Decode of a byte address into a register select
  function [2:0] reg_sel;
    input [11:0] a;
    begin
      case (a)
        `TOB_ADDR_DCP: reg_sel = sel_dcp;
        `TOB_ADDR_OBC: reg_sel = sel_obc;
        `TOB_ADDR_FLG: reg_sel = sel_flg;
        `TOB_ADDR_MSK: reg_sel = sel_msk;
        default: reg_sel = sel_none;
      endcase
    end
  endfunction

  // Apply one action code to the pin level
  function act_apply;
    input [1:0] code;
    input cur;
    begin
      case (code)
        `TOB_ACT_SET: act_apply = 1'b1;
        `TOB_ACT_TGL: act_apply = ~cur;
        `TOB_ACT_CLR: act_apply = 1'b0;
        default: act_apply = cur;
      endcase
    end
  endfunction

  wire do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [2:0] wsel = reg_sel(awaddr_r);
  wire wr_obc = do_wr && w_strb_r && (wsel == sel_obc);
  wire wr_flg = do_wr && w_strb_r && (wsel == sel_flg);
  wire wr_msk = do_wr && w_strb_r && (wsel == sel_msk);
  wire wr_dcp = do_wr && w_strb_r && (wsel == sel_dcp);

  // Effective action: AND of codes of coinciding events; absent events act as NOP
  reg [1:0] act_eff;
  always @* begin
    act_eff = `TOB_ACT_NOP;
    if (cmp0_match) begin
      act_eff = act_eff & {obc_r[`TOB_OBC_C0_HI], obc_r[`TOB_OBC_C0_LO]};
    end
    if (cmp1_match) begin
      act_eff = act_eff & {obc_r[`TOB_OBC_C1_HI], obc_r[`TOB_OBC_C1_LO]};
    end
    if (cnt_wrap) begin
      act_eff = act_eff & {obc_r[`TOB_OBC_OU_HI], obc_r[`TOB_OBC_OU_LO]};
    end
  end
  wire any_evt = cmp0_match | cmp1_match | cnt_wrap;

  // Software set of capture flags as simulated captures
  wire sw_cp0 = wr_flg && wdata_r[`TOB_FLG_CP0] && !flg_r[`TOB_FLG_CP0];
  wire sw_cp1 = wr_flg && wdata_r[`TOB_FLG_CP1] && !flg_r[`TOB_FLG_CP1] && !bicapture_mode;
  wire cp0_set = cap0_event | sw_cp0;
  wire cp1_set = cap1_event | sw_cp1;

  // Flag next values: write of 0 clears, hardware set wins
  reg [7:0] flg_nxt;
  always @* begin
    flg_nxt = flg_r;
    if (wr_flg) begin
      flg_nxt = flg_r & wdata_r;
      flg_nxt[`TOB_FLG_A0] = wdata_r[`TOB_FLG_A0];
      flg_nxt[`TOB_FLG_CP1] = flg_r[`TOB_FLG_CP1] & wdata_r[`TOB_FLG_CP1];
    end
    // Hardware sets come last so they win over a clear
    if (cp0_set) begin
      flg_nxt[`TOB_FLG_CP0] = 1'b1;
    end
    if (cp1_set) begin
      flg_nxt[`TOB_FLG_CP1] = 1'b1;
    end
    if (cmp0_match) begin
      flg_nxt[`TOB_FLG_CM0] = 1'b1;
    end
    if (cmp1_match) begin
      flg_nxt[`TOB_FLG_CM1] = 1'b1;
    end
    if (cnt_wrap) begin
      flg_nxt[`TOB_FLG_OUF] = 1'b1;
    end
    // Repeated request before clear, or software capture, is an overrun
    if ((cap0_dma_req | cap0_event) && flg_r[`TOB_FLG_CP0] || sw_cp0) begin
      flg_nxt[`TOB_FLG_CAPTURE_ZERO_OVERRUN] = 1'b1;
    end
    if ((cmp0_dma_req | cmp0_match) && flg_r[`TOB_FLG_CM0]) begin
      flg_nxt[`TOB_FLG_COMPARE_ZERO_OVERRUN] = 1'b1;
    end
  end

  // Mask next value: DMA masks drop at end of block, which wins over a write
  reg [7:0] msk_nxt;
  always @* begin
    msk_nxt = wr_msk ? wdata_r : msk_r;
    if (cap0_dma_eob) begin
      msk_nxt[`TOB_MSK_CAPTURE_ZERO_DMA_MASK] = 1'b0;
    end
    if (cmp0_dma_eob) begin
      msk_nxt[`TOB_MSK_COMPARE_ZERO_DMA_MASK] = 1'b0;
    end
  end

  // Interrupt sources with DMA end-of-block substitution
  wire gten = msk_r[`TOB_MSK_GLOBAL_TIMER_IRQ_ENABLE];
  wire cp0_src = msk_r[`TOB_MSK_CAPTURE_ZERO_DMA_MASK] ? cap0_dma_eob : flg_r[`TOB_FLG_CP0];
  wire cm0_src = msk_r[`TOB_MSK_COMPARE_ZERO_DMA_MASK] ? cmp0_dma_eob : flg_r[`TOB_FLG_CM0];
  wire cp0_on = cp0_src & msk_r[`TOB_MSK_CAPTURE_ZERO_IRQ_MASK];
  wire cp1_on = flg_r[`TOB_FLG_CP1] & msk_r[`TOB_MSK_CAPTURE_ONE_IRQ_MASK];
  wire cap_comb = flg_r[`TOB_FLG_A0] ? (cp0_on & cp1_on) : (cp0_on | cp1_on);
  wire cmp_comb = (cm0_src & msk_r[`TOB_MSK_COMPARE_ZERO_IRQ_MASK]) | (flg_r[`TOB_FLG_CM1] & msk_r[`TOB_MSK_COMPARE_ONE_IRQ_MASK]);
  wire wrp_comb = flg_r[`TOB_FLG_OUF] & msk_r[`TOB_MSK_OUI];

  // Pin B, preset write and action logic
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin_b <= 1'b0;
      obc_r <= 7'h00;
    end else begin
      if (wr_obc) begin
        obc_r <= wdata_r[7:1];
        timer_output_pin_b <= wdata_r[`TOB_OBC_OP];
      end
      if (any_evt) begin
        timer_output_pin_b <= act_apply(act_eff, timer_output_pin_b);
      end
    end
  end

  // Flag and mask registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flg_r <= `TOB_RST_BYTE;
      msk_r <= `TOB_RST_BYTE;
    end else begin
      flg_r <= flg_nxt;
      msk_r <= msk_nxt;
    end
  end

  // One-cycle pulses for the on-chip event and software captures
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_event_pulse <= 1'b0;
      sw_capture0_pulse <= 1'b0;
      sw_capture1_pulse <= 1'b0;
    end else begin
      wrap_event_pulse <= cnt_wrap & obc_r[`TOB_OBC_OEV];
      sw_capture0_pulse <= sw_cp0;
      sw_capture1_pulse <= sw_cp1;
    end
  end

  // Group interrupts; registered so the outputs never glitch
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_irq <= 1'b0;
      compare_irq <= 1'b0;
      wrap_irq <= 1'b0;
    end else begin
      capture_irq <= gten & cap_comb;
      compare_irq <= gten & cmp_comb;
      wrap_irq <= gten & wrp_comb;
    end
  end

  // DMA pointer; a software write wins over a swap toggle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= 6'h00;
      dir_r <= 1'b0;
      area_r <= 1'b0;
    end else begin
      dir_r <= dma_dir_cmp;
      if (wr_dcp) begin
        ptr_r <= wdata_r[7:2];
        area_r <= wdata_r[`TOB_DCP_AREA];
      end else if (swap_enable && cmp0_dma_eob) begin
        ptr_r[`TOB_DCP_PTR2] <= ~ptr_r[`TOB_DCP_PTR2];
      end
    end
  end

  // Register views, one cycle behind the registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_counter_pointer_q <= `TOB_RST_BYTE;
      interrupt_dma_mask_q <= `TOB_RST_BYTE;
    end else begin
      dma_counter_pointer_q <= {ptr_r, dir_r, area_r};
      interrupt_dma_mask_q <= msk_r;
    end
  end

  // Write address channel; refused until the response is taken
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r <= 12'h000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (do_wr) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel; only byte lane 0 carries register bits
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r <= 8'h00;
      w_strb_r <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (do_wr) begin
        w_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TOB_RESP_OKAY;
    end else begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == sel_none) ? `TOB_RESP_SLVERR : `TOB_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data; preset bit reads back the live pin level
  reg [7:0] rd_byte;
  always @* begin
    case (reg_sel(s_axi_araddr))
      sel_dcp: rd_byte = {ptr_r, dir_r, area_r};
      sel_obc: rd_byte = {obc_r, timer_output_pin_b};
      sel_flg: rd_byte = flg_r;
      sel_msk: rd_byte = msk_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // AXI read channel, one read at a time
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TOB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= (reg_sel(s_axi_araddr) == sel_none) ? `TOB_RESP_SLVERR : `TOB_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // tob_timer_out_b
`default_nettype wire

// File: bench/tob_pin_load.sv
`timescale 1ns/1ns
`default_nettype none
module tob_pin_load (
  input wire logic ref_clk, // Timer clock
  input wire logic rst_n, // Async reset
  input wire logic pin_b, // Pin level seen
  output logic [7:0] rise_cnt // Rising edges seen
);
  logic last_r;
  // Sample each cycle; pin is registered so no edge is missed
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 1'b0;
      rise_cnt <= 8'h00;
    end else begin
      last_r <= pin_b;
      if (pin_b && !last_r) rise_cnt <= rise_cnt + 8'h01;
    end
  end
endmodule // tob_pin_load
`default_nettype wire

// File: bench/tob_out_b_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tob_out_b_chk (
  input wire logic ref_clk, // Timer clock
  input wire logic rst_n, // Async reset
  input wire logic cnt_wrap, // Wrap in
  input wire logic bicapture_mode, // Bicapture in
  input wire logic cap0_dma_eob, // Capture-0 block end
  input wire logic cmp0_dma_eob, // Compare-0 block end
  input wire logic dma_dir_cmp, // Direction in
  input wire logic wrap_event_pulse, // Event out
  input wire logic sw_capture1_pulse, // Software capture 1
  input wire logic capture_irq, // Capture irq
  input wire logic compare_irq, // Compare irq
  input wire logic wrap_irq, // Wrap irq
  input wire logic [7:0] dma_counter_pointer_q, // Pointer view
  input wire logic [7:0] interrupt_dma_mask_q // Mask view
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Three cycles margin covers the view and irq lag
  sequence s_gbl_off;
    !interrupt_dma_mask_q[7] [*3];
  endsequence
  sequence s_wrap_armed;
    cnt_wrap && interrupt_dma_mask_q[7] && interrupt_dma_mask_q[0];
  endsequence
  property p_gate_off; s_gbl_off |-> !(capture_irq || compare_irq || wrap_irq); endproperty
  a_gate_off: assert property (p_gate_off) else $error("irq with global enable off");
  property p_wrap_pulse; wrap_event_pulse |-> $past(cnt_wrap); endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("event pulse without wrap");
  property p_wrap_gate; wrap_irq |-> interrupt_dma_mask_q[0] || $past(interrupt_dma_mask_q[0]); endproperty
  a_wrap_gate: assert property (p_wrap_gate) else $error("wrap irq while masked");
  property p_wrap_irq; s_wrap_armed |-> ##[1:3] wrap_irq; endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap irq missing");
  property p_capture_zero_dma_mask_clr; cap0_dma_eob |-> ##2 !interrupt_dma_mask_q[6]; endproperty
  a_capture_zero_dma_mask_clr: assert property (p_capture_zero_dma_mask_clr) else $error("capture DMA mask kept");
  property p_compare_zero_dma_mask_clr; cmp0_dma_eob |-> ##2 !interrupt_dma_mask_q[3]; endproperty
  a_compare_zero_dma_mask_clr: assert property (p_compare_zero_dma_mask_clr) else $error("compare DMA mask kept");
  property p_sw1; sw_capture1_pulse |-> !$past(bicapture_mode); endproperty
  a_sw1: assert property (p_sw1) else $error("capture 1 in bicapture");
  property p_dir; $past(rst_n) && $past(rst_n, 2) |-> dma_counter_pointer_q[1] == $past(dma_dir_cmp, 2); endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");
endmodule // tob_out_b_chk
bind tob_timer_out_b tob_out_b_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cnt_wrap(cnt_wrap),
  .bicapture_mode(bicapture_mode), .cap0_dma_eob(cap0_dma_eob), .cmp0_dma_eob(cmp0_dma_eob),
  .dma_dir_cmp(dma_dir_cmp), .wrap_event_pulse(wrap_event_pulse), .sw_capture1_pulse(sw_capture1_pulse),
  .capture_irq(capture_irq), .compare_irq(compare_irq), .wrap_irq(wrap_irq),
  .dma_counter_pointer_q(dma_counter_pointer_q), .interrupt_dma_mask_q(interrupt_dma_mask_q));
`default_nettype wire

// File: bench/tob_timer_out_b_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "tob_regs.vh"
module tob_timer_out_b_test;
  logic ref_clk = 0, rst_n = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, c;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cmp0_match, cmp1_match, cnt_wrap, cap0_event, cap1_event;
  logic cap0_dma_req, cmp0_dma_req, cap0_dma_eob, cmp0_dma_eob;
  logic bicapture_mode = 0, swap_enable = 0, dma_dir_cmp = 0, p = 0;
  logic timer_output_pin_b, wrap_event_pulse, sw_capture0_pulse, sw_capture1_pulse;
  logic capture_irq, compare_irq, wrap_irq;
  logic [7:0] dma_counter_pointer_q, interrupt_dma_mask_q, rise_cnt, o, e;
  logic [8:0] pv = 0;
  int n_fail = 0, comparisons = 0, cyc = 0, n_sw0 = 0, n_sw1 = 0, rises = 0;
  integer seed = 32'h4f526c0e;
  assign {cmp0_match, cmp1_match, cnt_wrap, cap0_event, cap1_event} = pv[8:4];
  assign {cap0_dma_req, cmp0_dma_req, cap0_dma_eob, cmp0_dma_eob} = pv[3:0];
  tob_timer_out_b dut (.*);
  tob_pin_load load (.ref_clk(ref_clk), .rst_n(rst_n), .pin_b(timer_output_pin_b), .rise_cnt(rise_cnt));
  initial forever #5 ref_clk = ~ref_clk;
  // Pulse monitors and the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (sw_capture0_pulse === 1'b1) n_sw0++;
    if (sw_capture1_pulse === 1'b1) n_sw1++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Model pin; counts rises the load should see
  task automatic setp(input logic np);
    if (np && !p) rises++;
    p = np;
  endtask
  // Bus write: each channel released once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, {24'h0, x});
    chk(s_axi_rresp, r);
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge ref_clk);
    pv <= v;
    @(posedge ref_clk);
    pv <= 9'h0;
    #1;
  endtask
  // Margin for the registered irq lag
  task automatic w2;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`TOB_ADDR_FLG, 8'h00, `TOB_RESP_OKAY);
    rd(`TOB_ADDR_MSK, 8'h00, `TOB_RESP_OKAY);
    rd(12'h004, 8'h00, `TOB_RESP_SLVERR);
    for (int i = 0; i < 32; i++) begin
      o = 8'($random(seed));
      e = 8'($random(seed));
      wr(`TOB_ADDR_OBC, o);
      setp(o[0]);
      pulse({e[2:0], 6'h00});
      c = 2'h3;
      if (e[2]) c = c & o[7:6];
      if (e[1]) c = c & o[5:4];
      if (e[0]) c = c & o[3:2];
      if (e[2:0] != 3'h0) setp(c == `TOB_ACT_SET ? 1'b1 : c == `TOB_ACT_TGL ? !p : c == `TOB_ACT_CLR ? 1'b0 : p);
      chk(timer_output_pin_b, p);
      chk(wrap_event_pulse, e[0] & o[1]);
      rd(`TOB_ADDR_OBC, {o[7:1], p}, `TOB_RESP_OKAY);
    end
    // Park all actions on NOP so later events leave the pin alone
    wr(`TOB_ADDR_OBC, 8'hfc);
    setp(1'b0);
    wr(`TOB_ADDR_FLG, 8'h00);
    rd(`TOB_ADDR_FLG, 8'h00, `TOB_RESP_OKAY);
    wr(`TOB_ADDR_MSK, 8'h81);
    pulse(9'h040);
    w2;
    chk(wrap_irq, 1);
    rd(`TOB_ADDR_FLG, 8'h08, `TOB_RESP_OKAY);
    wr(`TOB_ADDR_MSK, 8'h01);
    w2;
    chk(wrap_irq, 0);
    wr(`TOB_ADDR_MSK, 8'h80);
    w2;
    chk(wrap_irq, 0);
    wr(`TOB_ADDR_FLG, 8'h00);
    pulse(9'h100);
    pulse(9'h100);
    rd(`TOB_ADDR_FLG, 8'h22, `TOB_RESP_OKAY);
    wr(`TOB_ADDR_MSK, 8'h86);
    w2;
    chk(compare_irq, 1);
    wr(`TOB_ADDR_MSK, 8'h82);
    w2;
    chk(compare_irq, 0);
    wr(`TOB_ADDR_FLG, 8'h00);
    wr(`TOB_ADDR_FLG, 8'h80);
    rd(`TOB_ADDR_FLG, 8'h84, `TOB_RESP_OKAY);
    chk(n_sw0, 1);
    wr(`TOB_ADDR_FLG, 8'h00);
    bicapture_mode <= 1'b1;
    wr(`TOB_ADDR_FLG, 8'h40);
    w2;
    chk(n_sw1, 0);
    wr(`TOB_ADDR_FLG, 8'h00);
    bicapture_mode <= 1'b0;
    wr(`TOB_ADDR_FLG, 8'h40);
    w2;
    chk(n_sw1, 1);
    wr(`TOB_ADDR_MSK, 8'hb0);
    wr(`TOB_ADDR_FLG, 8'h01);
    pulse(9'h020);
    w2;
    chk(capture_irq, 0);
    pulse(9'h010);
    w2;
    chk(capture_irq, 1);
    wr(`TOB_ADDR_FLG, 8'h00);
    w2;
    chk(capture_irq, 0);
    pulse(9'h020);
    w2;
    chk(capture_irq, 1);
    wr(`TOB_ADDR_MSK, 8'h48);
    rd(`TOB_ADDR_MSK, 8'h48, `TOB_RESP_OKAY);
    pulse(9'h003);
    rd(`TOB_ADDR_MSK, 8'h00, `TOB_RESP_OKAY);
    swap_enable <= 1'b1;
    dma_dir_cmp <= 1'b1;
    wr(`TOB_ADDR_DCP, 8'hfd);
    rd(`TOB_ADDR_DCP, 8'hff, `TOB_RESP_OKAY);
    pulse(9'h001);
    rd(`TOB_ADDR_DCP, 8'hfb, `TOB_RESP_OKAY);
    swap_enable <= 1'b0;
    pulse(9'h001);
    rd(`TOB_ADDR_DCP, 8'hfb, `TOB_RESP_OKAY);
    chk(rise_cnt, rises[7:0]);
    end_of_test;
  end
endmodule // tob_timer_out_b_test
`default_nettype wire
